// >>> hdl/caw_pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; the level moves only when stages two and three agree
module caw_pin_sync
    import caw_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pinIn,
    output logic      level,
    output logic      fallPulse
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;
    logic next_fallPulse;

    always_comb begin
        next_level     = level;
        next_fallPulse = 1'b0;
        if (stage2 == stage3) begin
            next_level     = stage3;
            next_fallPulse = level & ~stage3;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1    <= 1'b0;
            stage2    <= 1'b0;
            stage3    <= 1'b0;
            level     <= 1'b0;
            fallPulse <= 1'b0;
        end else begin
            stage1    <= pinIn;
            stage2    <= stage1;
            stage3    <= stage2;
            level     <= next_level;
            fallPulse <= next_fallPulse;
        end
    end

endmodule : caw_pin_sync

// >>> hdl/caw_pkg.sv
// Operation
// - reset on low wrap while compare matches high
// - writing match flag one forces reset
// - compare high write restarts the timeout
// - timeout is 256*offset plus 256 minus low
// - timebase and idle locked while enabled
// - enable bit or lock bit enables watchdog
// - lock holds watchdog enabled until reset
// - unlocked, clearing enable disables watchdog
// - after reset enabled, divide by twelve, cleared
// - idle bit suspends counter during processor idle
// - enable bit resets to one, dedicates module
// - mode register at 0xD9, every page
// - three bit timebase select encoding
// - enabled blocks writes to other mode bits
// - bit zero gates overflow interrupt request
package caw_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE      = 8'hD9;
    localparam logic [7:0] ADDR_CTRL      = 8'hD8;
    localparam logic [7:0] ADDR_CNT_LOW   = 8'hF9;
    localparam logic [7:0] ADDR_CNT_HIGH  = 8'hFA;
    localparam logic [7:0] ADDR_OFFSET    = 8'hEB;
    localparam logic [7:0] ADDR_CMP_HIGH  = 8'hEC;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         MODE_IDLE_BIT  = 7;
    localparam int         MODE_ENBL_BIT  = 6;
    localparam int         MODE_LOCK_BIT  = 5;
    localparam int         MODE_TBS_LSB   = 1;
    localparam int         MODE_TBS_MSB   = 3;
    localparam int         MODE_IRQ_BIT   = 0;
    localparam int         CTRL_OV_BIT    = 7;
    localparam int         CTRL_MTCH_BIT  = 2;
    localparam logic       ENBL_RESET     = 1'b1;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [7:0] BYTE_ONES      = 8'hFF;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TBS_DIV12 = 3'b000,
        TBS_DIV4  = 3'b001,
        TBS_T0OVF = 3'b010,
        TBS_PIN   = 3'b011,
        TBS_SYS   = 3'b100,
        TBS_EXT8  = 3'b101,
        TBS_LFO8  = 3'b110,
        TBS_RSVD  = 3'b111
    } caw_tbs_t;

    localparam logic [3:0] PRESCALE_LAST  = 4'hB;
    localparam logic [3:0] PRESCALE_ZERO  = 4'h0;
    localparam logic [3:0] PRESCALE_ONE   = 4'h1;
    localparam logic [1:0] DIV4_LAST      = 2'h3;
    localparam logic [2:0] DIV8_LAST      = 3'h7;
    localparam logic [2:0] DIV8_ONE       = 3'h1;
    localparam logic [7:0] BYTE_ONE       = 8'h01;
    localparam int         NUM_PINS       = 3;
    localparam int         PIN_CNT        = 0;
    localparam int         PIN_EXT        = 1;
    localparam int         PIN_LFO        = 2;

endpackage : caw_pkg

// >>> hdl/caw_watchdog.sv
`timescale 1ns/1ps
module caw_watchdog
    import caw_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrWe,
    input  wire logic       sfrRe,
    output logic      [7:0] sfrRdData,
    input  wire logic       cpuIdle,
    input  wire logic       timer0Overflow,
    input  wire logic       externalCountInput,
    input  wire logic       extClkIn,
    input  wire logic       lfoClkIn,
    input  wire logic       resetSourceClear,
    output logic            watchdogResetReq,
    output logic            watchdogResetSource,
    output logic            overflowIrq
);

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    // the mode register answers on every page: no page qualifier exists
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    logic wrMode;
    logic wrCtrl;
    logic wrLow;
    logic wrHigh;
    logic wrOffset;
    logic wrCompare;

    assign wrMode    = sfrWe & hit(sfrAddr, ADDR_MODE);
    assign wrCtrl    = sfrWe & hit(sfrAddr, ADDR_CTRL);
    assign wrLow     = sfrWe & hit(sfrAddr, ADDR_CNT_LOW);
    assign wrHigh    = sfrWe & hit(sfrAddr, ADDR_CNT_HIGH);
    assign wrOffset  = sfrWe & hit(sfrAddr, ADDR_OFFSET);
    assign wrCompare = sfrWe & hit(sfrAddr, ADDR_CMP_HIGH);

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pinRaw;
    logic [NUM_PINS-1:0] pinFall;

    assign pinRaw[PIN_CNT] = externalCountInput;
    assign pinRaw[PIN_EXT] = extClkIn;
    assign pinRaw[PIN_LFO] = lfoClkIn;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_sync
            caw_pin_sync u_sync (
                .sys_clk   (sys_clk),
                .rstn      (rstn),
                .pinIn     (pinRaw[g]),
                .level     (),
                .fallPulse (pinFall[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // mode and control state
    // ------------------------------------------------------------
    logic       idleSuspend;
    logic       watchdogEnable;
    logic       watchdogLock;
    caw_tbs_t   timebaseSelect;
    logic       overflowIrqEnable;
    logic       counterOverflowFlag;
    logic       module2MatchFlag;
    logic [7:0] offsetValue;
    logic [7:0] compareHigh;

    logic       next_idleSuspend;
    logic       next_watchdogEnable;
    logic       next_watchdogLock;
    caw_tbs_t   next_timebaseSelect;
    logic       next_overflowIrqEnable;
    logic       next_counterOverflowFlag;
    logic       next_module2MatchFlag;
    logic [7:0] next_offsetValue;
    logic [7:0] next_compareHigh;

    logic       watchdogActive;
    logic       lowWrap;
    logic       highWrap;
    logic [7:0] countLow;
    logic [7:0] countHigh;

    assign watchdogActive = watchdogEnable | watchdogLock;

    always_comb begin
        next_idleSuspend         = idleSuspend;
        next_watchdogEnable      = watchdogEnable;
        next_watchdogLock        = watchdogLock;
        next_timebaseSelect      = timebaseSelect;
        next_overflowIrqEnable   = overflowIrqEnable;
        next_counterOverflowFlag = counterOverflowFlag;
        next_module2MatchFlag    = module2MatchFlag;
        next_offsetValue         = offsetValue;
        next_compareHigh         = compareHigh;

        if (wrMode) begin
            if (watchdogEnable) begin
                // while enabled only the enable bit itself may move, and only when unlocked
                if (!watchdogLock && !sfrWrData[MODE_ENBL_BIT]) begin
                    next_watchdogEnable = 1'b0;
                end
            end else begin
                // other fields accepted only while disabled
                next_idleSuspend       = sfrWrData[MODE_IDLE_BIT];
                next_timebaseSelect    = caw_tbs_t'(sfrWrData[MODE_TBS_MSB:MODE_TBS_LSB]);
                next_overflowIrqEnable = sfrWrData[MODE_IRQ_BIT];
                next_watchdogLock      = sfrWrData[MODE_LOCK_BIT];
                next_watchdogEnable    = sfrWrData[MODE_ENBL_BIT] | sfrWrData[MODE_LOCK_BIT];
            end
        end

        if (wrCtrl) begin
            // software may only clear the overflow flag; module flag written as given
            if (!sfrWrData[CTRL_OV_BIT]) begin
                next_counterOverflowFlag = 1'b0;
            end
            next_module2MatchFlag = sfrWrData[CTRL_MTCH_BIT];
        end
        // set wins over a same-cycle clear
        if (highWrap) begin
            next_counterOverflowFlag = 1'b1;
        end

        if (wrOffset) begin
            next_offsetValue = sfrWrData;
        end

        if (wrCompare) begin
            if (watchdogActive) begin
                // restart: next match lands offset high-byte steps past the current one
                next_compareHigh = countHigh + offsetValue;
            end else begin
                next_compareHigh = sfrWrData;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            idleSuspend         <= 1'b0;
            watchdogEnable      <= ENBL_RESET;
            watchdogLock        <= 1'b0;
            timebaseSelect      <= TBS_DIV12;
            overflowIrqEnable   <= 1'b0;
            counterOverflowFlag <= 1'b0;
            module2MatchFlag    <= 1'b0;
            offsetValue         <= BYTE_ZERO;
            compareHigh         <= BYTE_ZERO;
        end else begin
            idleSuspend         <= next_idleSuspend;
            watchdogEnable      <= next_watchdogEnable;
            watchdogLock        <= next_watchdogLock;
            timebaseSelect      <= next_timebaseSelect;
            overflowIrqEnable   <= next_overflowIrqEnable;
            counterOverflowFlag <= next_counterOverflowFlag;
            module2MatchFlag    <= next_module2MatchFlag;
            offsetValue         <= next_offsetValue;
            compareHigh         <= next_compareHigh;
        end
    end

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    logic [3:0] prescale;
    logic [2:0] extDiv;
    logic [2:0] lfoDiv;
    logic [3:0] next_prescale;
    logic [2:0] next_extDiv;
    logic [2:0] next_lfoDiv;
    logic       baseTick;
    logic       pcaTick;

    always_comb begin
        next_prescale = (prescale == PRESCALE_LAST) ? PRESCALE_ZERO : prescale + PRESCALE_ONE;
        next_extDiv   = pinFall[PIN_EXT] ? extDiv + DIV8_ONE : extDiv;
        next_lfoDiv   = pinFall[PIN_LFO] ? lfoDiv + DIV8_ONE : lfoDiv;
        case (timebaseSelect)
            TBS_DIV12: baseTick = (prescale == PRESCALE_LAST);
            TBS_DIV4:  baseTick = (prescale[1:0] == DIV4_LAST);
            TBS_T0OVF: baseTick = timer0Overflow;
            TBS_PIN:   baseTick = pinFall[PIN_CNT];
            TBS_SYS:   baseTick = 1'b1;
            TBS_EXT8:  baseTick = pinFall[PIN_EXT] && (extDiv == DIV8_LAST);
            TBS_LFO8:  baseTick = pinFall[PIN_LFO] && (lfoDiv == DIV8_LAST);
            default:   baseTick = 1'b0;
        endcase
        pcaTick = baseTick & ~(idleSuspend & cpuIdle);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= PRESCALE_ZERO;
            extDiv   <= '0;
            lfoDiv   <= '0;
        end else begin
            prescale <= next_prescale;
            extDiv   <= next_extDiv;
            lfoDiv   <= next_lfoDiv;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [7:0] next_countLow;
    logic [7:0] next_countHigh;

    assign lowWrap  = pcaTick && (countLow == BYTE_ONES);
    assign highWrap = lowWrap && (countHigh == BYTE_ONES);

    always_comb begin
        next_countLow  = countLow;
        next_countHigh = countHigh;
        if (pcaTick) begin
            next_countLow = countLow + BYTE_ONE;
        end
        if (lowWrap) begin
            next_countHigh = countHigh + BYTE_ONE;
        end
        // direct loads would let software dodge the timeout, so only while disabled
        if (!watchdogActive && wrLow) begin
            next_countLow = sfrWrData;
        end
        if (!watchdogActive && wrHigh) begin
            next_countHigh = sfrWrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            countLow  <= BYTE_ZERO;
            countHigh <= BYTE_ZERO;
        end else begin
            countLow  <= next_countLow;
            countHigh <= next_countHigh;
        end
    end

    // ------------------------------------------------------------
    // reset request and outputs
    // ------------------------------------------------------------
    logic       fire;
    logic       next_watchdogResetSource;
    logic       next_overflowIrq;
    logic [7:0] next_sfrRdData;

    always_comb begin
        fire = watchdogActive && ((lowWrap && compareHigh == countHigh)
               || (wrCtrl && sfrWrData[CTRL_MTCH_BIT]));
        next_watchdogResetSource = watchdogResetSource;
        if (resetSourceClear) begin
            next_watchdogResetSource = 1'b0;
        end
        if (fire) begin
            next_watchdogResetSource = 1'b1;
        end
        next_overflowIrq = counterOverflowFlag & overflowIrqEnable;
        next_sfrRdData   = BYTE_ZERO;
        if (sfrRe) begin
            case (1'b1)
                hit(sfrAddr, ADDR_MODE): begin
                    next_sfrRdData[MODE_IDLE_BIT]              = idleSuspend;
                    next_sfrRdData[MODE_ENBL_BIT]              = watchdogEnable;
                    next_sfrRdData[MODE_LOCK_BIT]              = watchdogLock;
                    next_sfrRdData[MODE_TBS_MSB:MODE_TBS_LSB]  = timebaseSelect;
                    next_sfrRdData[MODE_IRQ_BIT]               = overflowIrqEnable;
                end
                hit(sfrAddr, ADDR_CTRL): begin
                    next_sfrRdData[CTRL_OV_BIT]   = counterOverflowFlag;
                    next_sfrRdData[CTRL_MTCH_BIT] = module2MatchFlag;
                end
                hit(sfrAddr, ADDR_CNT_LOW):  next_sfrRdData = countLow;
                hit(sfrAddr, ADDR_CNT_HIGH): next_sfrRdData = countHigh;
                hit(sfrAddr, ADDR_OFFSET):   next_sfrRdData = offsetValue;
                hit(sfrAddr, ADDR_CMP_HIGH): next_sfrRdData = compareHigh;
                default:                     next_sfrRdData = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            watchdogResetReq    <= 1'b0;
            watchdogResetSource <= 1'b0;
            overflowIrq         <= 1'b0;
            sfrRdData           <= BYTE_ZERO;
        end else begin
            watchdogResetReq    <= fire;
            watchdogResetSource <= next_watchdogResetSource;
            overflowIrq         <= next_overflowIrq;
            sfrRdData           <= next_sfrRdData;
        end
    end

endmodule : caw_watchdog

// >>> tb/caw_wd_asserts.sv
`timescale 1ns/1ps
module caw_wd_asserts
    import caw_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic       sfrWe,
    input wire logic       sfrRe,
    input wire logic [7:0] sfrRdData,
    input wire logic       resetSourceClear,
    input wire logic       watchdogResetReq,
    input wire logic       watchdogResetSource
);
    // ------------------------------------------------------------
    // shadow of enable and lock, cycles since reset
    // ------------------------------------------------------------
    logic        wdOn, wdLock, quiet, next_wdOn, next_wdLock, next_quiet;
    logic [11:0] cycles, next_cycles;

    always_comb begin
        next_wdOn   = wdOn;
        next_wdLock = wdLock;
        next_quiet  = quiet && !sfrWe;
        next_cycles = (cycles == 12'hFFF) ? cycles : cycles + 12'h001;
        if (sfrWe && sfrAddr == ADDR_MODE) begin
            // while enabled only the enable bit is taken, so lock can only come from disabled
            next_wdLock = wdLock | (!wdOn & sfrWrData[MODE_LOCK_BIT]);
            next_wdOn   = wdLock | sfrWrData[MODE_ENBL_BIT] | (!wdOn & sfrWrData[MODE_LOCK_BIT]);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdOn   <= 1'h1;
            wdLock <= 1'h0;
            quiet  <= 1'h1;
            cycles <= 12'h000;
        end else begin
            wdOn   <= next_wdOn;
            wdLock <= next_wdLock;
            quiet  <= next_quiet;
            cycles <= next_cycles;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_req_single_cycle: assert property (watchdogResetReq |=> !watchdogResetReq)
        else $error("reset request longer than one cycle");
    a_source_with_req: assert property (watchdogResetReq |-> watchdogResetSource)
        else $error("reset source not recorded with request");
    a_source_stays: assert property (watchdogResetSource && !resetSourceClear |=> watchdogResetSource)
        else $error("reset source dropped without clear");
    a_force_fires: assert property (sfrWe && sfrAddr == ADDR_CTRL && sfrWrData[CTRL_MTCH_BIT] && wdOn
        |=> watchdogResetReq)
        else $error("forced reset missing");
    a_off_no_req: assert property (watchdogResetReq |-> $past(wdOn))
        else $error("reset request while watchdog disabled");
    a_mode_readback: assert property (sfrRe && sfrAddr == ADDR_MODE |=> sfrRdData[MODE_ENBL_BIT] == $past(wdOn)
        && sfrRdData[MODE_LOCK_BIT] == $past(wdLock) && !sfrRdData[4])
        else $error("mode read disagrees with enable or lock");
    a_rd_idle_zero: assert property (!sfrRe |=> sfrRdData == BYTE_ZERO)
        else $error("read data not zero without read");
    a_first_wait: assert property (quiet && cycles < 12'hC00 |-> !watchdogResetReq)
        else $error("default timeout fired early");
    a_first_fire: assert property (quiet && cycles == 12'hC00 |-> watchdogResetReq)
        else $error("default timeout not fired on time");

    c_default_fire: cover property (quiet && watchdogResetReq);
    c_forced: cover property (sfrWe && sfrAddr == ADDR_CTRL && sfrWrData[CTRL_MTCH_BIT] && wdOn);
    c_locked_write: cover property (wdLock && sfrWe && sfrAddr == ADDR_MODE);
endmodule : caw_wd_asserts

bind caw_watchdog caw_wd_asserts u_chk (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .sfrAddr            (sfrAddr),
    .sfrWrData          (sfrWrData),
    .sfrWe              (sfrWe),
    .sfrRe              (sfrRe),
    .sfrRdData          (sfrRdData),
    .resetSourceClear   (resetSourceClear),
    .watchdogResetReq   (watchdogResetReq),
    .watchdogResetSource(watchdogResetSource)
);

// >>> tb/test_counter_array_watchdog.sv
`timescale 1ns/1ps
`define CAW_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module test_counter_array_watchdog
    import caw_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] expRd;} caw_row_t;
    // rows run after the timebase loop leaves the watchdog disabled
    // the disabling write keeps the other fields; a second write then selects the timer 0 timebase
    localparam caw_row_t ROWS [15] = '{
        '{8'hD9, 8'h00, 8'h00}, '{8'hD9, 8'h9F, 8'h8F}, '{8'hD9, 8'h42, 8'h42}, '{8'hD9, 8'hC0, 8'h42},
        '{8'hD9, 8'h04, 8'h02}, '{8'hD9, 8'h04, 8'h04}, '{8'hD8, 8'h04, 8'h04}, '{8'hD8, 8'h00, 8'h00},
        '{8'hF9, 8'hF0, 8'hF0}, '{8'hFA, 8'h00, 8'h00}, '{8'hEB, 8'h01, 8'h01}, '{8'hD9, 8'h24, 8'h64},
        '{8'hD9, 8'h00, 8'h64}, '{8'h12, 8'hAA, 8'h00}, '{8'hF9, 8'h00, 8'hF0}};

    logic       sys_clk, rstn, sfrWe, sfrRe, cpuIdle, timer0Overflow, resetSourceClear;
    logic       externalCountInput, extClkIn, lfoClkIn, watchdogResetReq, watchdogResetSource, overflowIrq;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, v, lowModel;
    int         n_fail, num_checks, reqCount, n;

    caw_watchdog dut (
        .sys_clk(sys_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWe(sfrWe),
        .sfrRe(sfrRe), .sfrRdData(sfrRdData), .cpuIdle(cpuIdle), .timer0Overflow(timer0Overflow),
        .externalCountInput(externalCountInput), .extClkIn(extClkIn), .lfoClkIn(lfoClkIn),
        .resetSourceClear(resetSourceClear), .watchdogResetReq(watchdogResetReq),
        .watchdogResetSource(watchdogResetSource), .overflowIrq(overflowIrq));

    // ------------------------------------------------------------
    // clock, monitor, tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) if (watchdogResetReq === 1'h1) reqCount++;

    task automatic do_reset;
        rstn = 1'h0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'h1;
        reqCount = 0;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWe = 1'h1;
        @(negedge sys_clk);
        sfrWe = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfrAddr = a;
        sfrRe = 1'h1;
        @(negedge sys_clk);
        sfrRe = 1'h0;
        d = sfrRdData;
    endtask : rd

    task automatic pulse(input int cnt);
        repeat (cnt) begin
            @(negedge sys_clk);
            timer0Overflow = 1'h1;
            @(negedge sys_clk);
            timer0Overflow = 1'h0;
        end
        lowModel = lowModel + 8'(cnt);
    endtask : pulse

    // restart, then the request must come on exactly the computed tick
    task automatic restart_check;
        int expTicks;
        wr(ADDR_CMP_HIGH, 8'h00);
        expTicks = 256 * 1 + 256 - int'(lowModel);
        reqCount = 0;
        pulse(expTicks - 1);
        `CAW_CHK(reqCount, 0)
        pulse(1);
        repeat (2) @(negedge sys_clk);
        `CAW_CHK(reqCount, 1)
    endtask : restart_check

    task automatic test_done;
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {sfrWe, sfrRe, cpuIdle, timer0Overflow, resetSourceClear} = 5'h00;
        {externalCountInput, extClkIn, lfoClkIn} = 3'h7;
        {sfrAddr, sfrWrData} = 16'h0000;
        n_fail = 0;
        num_checks = 0;
        do_reset();
        n = 0;
        while (watchdogResetReq !== 1'h1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        `CAW_CHK(n, 3072)
        @(negedge sys_clk);
        `CAW_CHK(watchdogResetReq, 1'h0)
        `CAW_CHK(watchdogResetSource, 1'h1)
        rd(ADDR_MODE, v);
        `CAW_CHK(v, 8'h40)
        rd(ADDR_OFFSET, v);
        `CAW_CHK(v, 8'h00)
        resetSourceClear = 1'h1;
        @(negedge sys_clk);
        resetSourceClear = 1'h0;
        `CAW_CHK(watchdogResetSource, 1'h0)
        do_reset();
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MODE, {4'h0, 3'(i), 1'h0});
            rd(ADDR_MODE, v);
            `CAW_CHK(v, {4'h0, 3'(i), 1'h0})
        end
        foreach (ROWS[i]) begin
            wr(ROWS[i].addr, ROWS[i].data);
            rd(ROWS[i].addr, v);
            `CAW_CHK(v, ROWS[i].expRd)
        end
        `CAW_CHK(reqCount, 0)
        lowModel = 8'hF0;
        restart_check();
        wr(ADDR_CMP_HIGH, 8'h00);
        pulse(100);
        restart_check();
        reqCount = 0;
        wr(ADDR_CTRL, 8'h04);
        @(negedge sys_clk);
        `CAW_CHK(reqCount, 1)
        `CAW_CHK(watchdogResetSource, 1'h1)
        // disabled: idle suspension, counter wrap onto a matching compare, falling-edge input
        do_reset();
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_MODE, 8'h85);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CNT_LOW, 8'hFF);
        wr(ADDR_CMP_HIGH, 8'hFF);
        cpuIdle = 1'h1;
        pulse(1);
        rd(ADDR_CNT_LOW, v);
        `CAW_CHK(v, 8'hFF)
        `CAW_CHK(overflowIrq, 1'h0)
        cpuIdle = 1'h0;
        pulse(1);
        @(negedge sys_clk);
        `CAW_CHK(overflowIrq, 1'h1)
        rd(ADDR_CTRL, v);
        `CAW_CHK(v, 8'h80)
        `CAW_CHK(reqCount, 0)
        wr(ADDR_MODE, 8'h06);
        externalCountInput = 1'h0;
        repeat (8) @(negedge sys_clk);
        rd(ADDR_CNT_LOW, v);
        `CAW_CHK(v, 8'h01)
        test_done();
    end
endmodule : test_counter_array_watchdog
